// [core/comparator_timer_gate_sync.sv]
// Notes on behaviour
// - Gate source bit: comparator when clear, pin set
// - Comparator gating only with timer on, gating enabled
// - Sync bit latches comparator on timer clock fall
// - Latch uses prescaler output as its clock
// - Timer counts on rising timer clock edges
// - Bits 7 and 6 mirror both comparator outputs
// - Mirror reads leave mismatch latches alone
// - Bit 5 always reads zero
// - Bits 3 and 2 enable hysteresis, one enables
// - Reference enable; clear clamps output to ground
// - Range bit and 4-bit level field
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "cmp_aux_defines.svh"

module comparator_timer_gate_sync #(
	parameter int ADDR_W = `APB_ADDR_W,
	parameter int PRESCALE_W = `PRESCALE_W
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Comparators and timer
	input wire logic cmp_a_output,
	input wire logic cmp_b_output,
	input wire logic timer_gate_pin,
	input wire logic timer_on,
	input wire logic timer_gate_enable,
	input wire logic [PRESCALE_W-1:0] timer_prescale,
	output cmp_aux_pkg::tick_t timer_clk,
	output logic timer_increment,
	output logic synced_cmp_b_output,
	output logic timer_gate,
	output logic timer_alt_clock_select,
	// Analog controls
	output logic cmp_a_hysteresis_enable,
	output logic cmp_b_hysteresis_enable,
	output logic vref_enable,
	output logic vref_clamp,
	output logic vref_range_select,
	output logic [`VREF_LEVEL_MSB:0] vref_level
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [`AUX_WR_W-1:0] aux_q; // Writable auxiliary bits
	logic [7:0] vref_q; // Reference control bits
	cmp_aux_pkg::aux_ctrl_t aux_view; // Register as software reads it
	logic [31:0] prdata_q; // Read data captured in setup
	logic pslverr_q; // Unmapped address flag
	logic setup; // APB setup cycle
	logic wr_acc; // APB write access cycle
	logic [1:0] hit; // Decoded register select
	logic [1:0] setup_hit; // Decode of the setup address

	// Assertions sample on the rising edge and rest in reset
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// One-hot select: bit 0 auxiliary, bit 1 reference
	function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
		logic [1:0] h;
		h = 2'h0;
		h[0] = (a == `AUX_CTRL_OFFSET);
		h[1] = (a == `VREF_CTRL_OFFSET);
		return h;
	endfunction

	// ----------------------------------------
	// APB handshake
	// ----------------------------------------
	// Zero wait states: every access completes in one cycle
	assign pready = psel & penable;
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign hit = decode(paddr);
	assign setup_hit = decode(paddr);
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------
	// Auxiliary control register
	// ----------------------------------------
	// Software writes only the low five bits
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			aux_q <= `AUX_WR_RESET;
		end else if (wr_acc && hit[0] && pstrb[0]) begin
			aux_q <= pwdata[`AUX_WR_W-1:0];
		end
	end

	// Mirrors are live comparator levels; a read changes nothing
	always_comb begin
		aux_view.mirror_a = cmp_a_output;
		aux_view.mirror_b = cmp_b_output;
		aux_view.unused = 1'b0;
		aux_view.alt_clk = aux_q[`BIT_ALT_CLK];
		aux_view.a_hys = aux_q[`BIT_A_HYS];
		aux_view.b_hys = aux_q[`BIT_B_HYS];
		aux_view.gate_src = aux_q[`BIT_GATE_SRC];
		aux_view.sync_en = aux_q[`BIT_SYNC];
	end

	// ----------------------------------------
	// Reference control register
	// ----------------------------------------
	// Reserved bits are dropped on write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			vref_q <= `VREF_RESET;
		end else if (wr_acc && hit[1] && pstrb[0]) begin
			vref_q <= pwdata[7:0] & `VREF_WR_MASK;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Sampled in setup, so data is stable through access
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			if (setup_hit[0]) begin
				prdata_q <= {24'h00_0000, aux_view};
			end else if (setup_hit[1]) begin
				prdata_q <= {24'h00_0000, vref_q};
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Error answer for an address outside the map
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pslverr_q <= 1'b0;
		end else if (setup) begin
			pslverr_q <= (setup_hit == 2'h0);
		end
	end

	// ----------------------------------------
	// Timer clock and comparator sync
	// ----------------------------------------
	// Selected source, then prescaler, then edge pulses
	timer_clock_gen #(
		.PRESCALE_W(PRESCALE_W)
	) u_clk (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.alt_sel(aux_q[`BIT_ALT_CLK]),
		.prescale(timer_prescale),
		.tick(timer_clk)
	);

	// Comparator latched on the post-prescaler falling edge
	cmp_sync_latch u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.fall(timer_clk.fall),
		.sync_en(aux_q[`BIT_SYNC]),
		.cmp_raw(cmp_b_output),
		.cmp_out(synced_cmp_b_output)
	);

	// ----------------------------------------
	// Gate and increment
	// ----------------------------------------
	// Pin when the select bit is set, comparator otherwise
	assign timer_gate = aux_q[`BIT_GATE_SRC] ? timer_gate_pin : synced_cmp_b_output;

	// Gate counts only when timer runs and gating is on
	assign timer_increment = timer_clk.rise & timer_on
		& (~timer_gate_enable | timer_gate);

	// ----------------------------------------
	// Analog control outputs
	// ----------------------------------------
	assign timer_alt_clock_select = aux_q[`BIT_ALT_CLK];
	assign cmp_a_hysteresis_enable = aux_q[`BIT_A_HYS];
	assign cmp_b_hysteresis_enable = aux_q[`BIT_B_HYS];
	assign vref_enable = vref_q[`VREF_EN_BIT];
	// Clamp holds the reference at ground with no current drawn
	assign vref_clamp = ~vref_q[`VREF_EN_BIT];
	assign vref_range_select = vref_q[`VREF_RANGE_BIT];
	assign vref_level = vref_q[`VREF_LEVEL_MSB:0];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Pin selected
	gate_pin_sel_a: assert property (
		aux_q[`BIT_GATE_SRC] |-> timer_gate == timer_gate_pin)
		else $error("gate does not follow the pin");

	// Comparator selected without sync
	gate_cmp_raw_a: assert property (
		!aux_q[`BIT_GATE_SRC] && !aux_q[`BIT_SYNC] |-> timer_gate == cmp_b_output)
		else $error("gate does not follow raw comparator");

	// Increment needs running timer and open gate
	incr_gated_a: assert property (
		timer_increment |-> timer_on && (!timer_gate_enable || timer_gate))
		else $error("increment while gated off");

	// Ungated timer counts every rising edge
	incr_free_a: assert property (
		timer_clk.rise && timer_on && !timer_gate_enable |-> timer_increment)
		else $error("increment lost with gating off");

	// Latched value holds between falling edges
	sync_hold_a: assert property (
		aux_q[`BIT_SYNC] && !timer_clk.fall ##1 aux_q[`BIT_SYNC]
		|-> $stable(synced_cmp_b_output))
		else $error("synced output moved without a falling edge");

	// Falling edge captures the comparator
	sync_capture_a: assert property (
		timer_clk.fall ##1 aux_q[`BIT_SYNC] |-> synced_cmp_b_output == $past(cmp_b_output))
		else $error("falling edge capture wrong");

	// Counting only on rising edges
	rise_only_a: assert property (
		timer_increment |-> timer_clk.rise && !timer_clk.fall)
		else $error("increment off the rising edge");

	// Mirrors read both comparators from setup
	mirror_read_a: assert property (
		setup && paddr == `AUX_CTRL_OFFSET |=> prdata[7] == $past(cmp_a_output)
		&& prdata[6] == $past(cmp_b_output))
		else $error("mirror bits wrong");

	// Unimplemented bit reads zero
	unused_zero_a: assert property (
		pready && !pwrite && paddr == `AUX_CTRL_OFFSET |-> prdata[5] == 1'b0)
		else $error("bit 5 read as one");

	// Reads leave control bits untouched
	read_no_effect_a: assert property (
		pready && !pwrite |=> $stable(aux_q) && $stable(vref_q))
		else $error("read changed a register");

	// Written hysteresis bits reach the comparators
	hys_write_a: assert property (
		wr_acc && paddr == `AUX_CTRL_OFFSET && pstrb[0]
		|=> cmp_a_hysteresis_enable == $past(pwdata[`BIT_A_HYS])
		&& cmp_b_hysteresis_enable == $past(pwdata[`BIT_B_HYS]))
		else $error("hysteresis enable not written");

	// Written level and clamp reach the reference
	vref_write_a: assert property (
		wr_acc && paddr == `VREF_CTRL_OFFSET && pstrb[0]
		|=> vref_level == $past(pwdata[`VREF_LEVEL_MSB:0])
		&& vref_clamp == !$past(pwdata[`VREF_EN_BIT]))
		else $error("reference control not written");

	// Written alternate clock bit reaches the timer
	alt_clk_write_a: assert property (
		wr_acc && paddr == `AUX_CTRL_OFFSET && pstrb[0]
		|=> timer_alt_clock_select == $past(pwdata[`BIT_ALT_CLK]))
		else $error("alternate clock select not written");

	// Written gate source and sync bits are kept
	gate_bits_write_a: assert property (
		wr_acc && paddr == `AUX_CTRL_OFFSET && pstrb[0]
		|=> aux_view.gate_src == $past(pwdata[`BIT_GATE_SRC])
		&& aux_view.sync_en == $past(pwdata[`BIT_SYNC]))
		else $error("gate control bits not written");

	// Written enable and range reach the reference
	vref_en_write_a: assert property (
		wr_acc && paddr == `VREF_CTRL_OFFSET && pstrb[0]
		|=> vref_enable == $past(pwdata[`VREF_EN_BIT])
		&& vref_range_select == $past(pwdata[`VREF_RANGE_BIT]))
		else $error("reference enable or range not written");

	// Write without the low strobe changes nothing
	strobe_mask_a: assert property (
		wr_acc && !pstrb[0] |=> $stable(aux_q) && $stable(vref_q))
		else $error("masked write changed a register");

	// Mirrors in the access cycle show setup levels
	mirror_access_a: assert property (
		pready && !pwrite && paddr == `AUX_CTRL_OFFSET
		|-> prdata[7] == $past(cmp_a_output) && prdata[6] == $past(cmp_b_output))
		else $error("mirror bits wrong in access");

	// Writable auxiliary bits read back as stored
	aux_read_a: assert property (
		pready && !pwrite && paddr == `AUX_CTRL_OFFSET
		|-> prdata[`AUX_WR_W-1:0] == aux_q)
		else $error("auxiliary bits read back wrong");

	// Reference register reads back as stored
	vref_read_a: assert property (
		pready && !pwrite && paddr == `VREF_CTRL_OFFSET
		|-> prdata == {24'h00_0000, vref_q})
		else $error("reference register read back wrong");

	// Bits above the byte always read zero
	upper_zero_a: assert property (
		pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");

	// Comparator selected with sync uses latched level
	gate_cmp_sync_a: assert property (
		!aux_q[`BIT_GATE_SRC] && aux_q[`BIT_SYNC] |-> timer_gate == synced_cmp_b_output)
		else $error("gate does not follow synced comparator");

	// Sync off passes the comparator straight through
	sync_raw_a: assert property (
		!aux_q[`BIT_SYNC] |-> synced_cmp_b_output == cmp_b_output)
		else $error("unsynced comparator not passed through");

	// Timer clock edges never coincide
	tick_excl_a: assert property (
		!(timer_clk.rise && timer_clk.fall))
		else $error("rise and fall in one cycle");

	// Open gate lets a running timer count
	incr_open_a: assert property (
		timer_clk.rise && timer_on && timer_gate_enable && timer_gate |-> timer_increment)
		else $error("increment lost with gate open");

	// Stopped timer never counts
	timer_off_a: assert property (
		!timer_on |-> !timer_increment)
		else $error("increment while timer off");

	// Access phase never waits
	zero_wait_a: assert property (
		psel && penable |-> pready)
		else $error("access phase not ready");

	// Unmapped address answers with an error
	unmapped_err_a: assert property (
		pready && paddr != `AUX_CTRL_OFFSET && paddr != `VREF_CTRL_OFFSET |-> pslverr)
		else $error("unmapped access without error");

	// Mapped address answers cleanly
	mapped_ok_a: assert property (
		pready && (paddr == `AUX_CTRL_OFFSET || paddr == `VREF_CTRL_OFFSET)
		|-> !pslverr)
		else $error("mapped access flagged as error");

endmodule

// [include/cmp_aux_defines.svh]
`ifndef CMP_AUX_DEFINES_SVH
`define CMP_AUX_DEFINES_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define APB_ADDR_W 12
`define AUX_CTRL_OFFSET 12'h000
`define VREF_CTRL_OFFSET 12'h004

// ----------------------------------------
// Auxiliary control register fields
// ----------------------------------------
`define BIT_SYNC 0
`define BIT_GATE_SRC 1
`define BIT_B_HYS 2
`define BIT_A_HYS 3
`define BIT_ALT_CLK 4
`define AUX_WR_W 5
`define AUX_WR_RESET 5'h02

// ----------------------------------------
// Reference control register fields
// ----------------------------------------
`define VREF_EN_BIT 7
`define VREF_RANGE_BIT 5
`define VREF_LEVEL_MSB 3
`define VREF_WR_MASK 8'hAF
`define VREF_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define INSTR_DIV_LAST 2'h3
`define PRESCALE_W 2

`endif

// [include/cmp_aux_pkg.sv]
package cmp_aux_pkg;

	// Read view of the auxiliary control register
	typedef struct packed {
		logic mirror_a;
		logic mirror_b;
		logic unused;
		logic alt_clk;
		logic a_hys;
		logic b_hys;
		logic gate_src;
		logic sync_en;
	} aux_ctrl_t;

	// Timer clock edges as one-cycle pulses
	typedef struct packed {
		logic rise;
		logic fall;
	} tick_t;

endpackage

// [core/timer_clock_gen.sv]
`timescale 1ns/1ps
`include "cmp_aux_defines.svh"

module timer_clock_gen #(
	parameter int PRESCALE_W = `PRESCALE_W
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic alt_sel,
	input wire logic [PRESCALE_W-1:0] prescale,
	output cmp_aux_pkg::tick_t tick
);

	// ----------------------------------------
	// Source clock enables
	// ----------------------------------------
	logic [1:0] instr_cnt_q; // Oscillator divided by four
	logic src_pulse; // One source clock period elapsed
	logic [(1<<PRESCALE_W)-1:0] psc_cnt_q; // Prescaler chain
	logic clk_bit_q; // Post-prescaler timer clock level
	logic clk_prev_q; // Level one cycle earlier

	// Instruction clock divider, free running
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			instr_cnt_q <= 2'h0;
		end else begin
			instr_cnt_q <= instr_cnt_q + 2'h1;
		end
	end

	// System clock every cycle, else instruction clock
	assign src_pulse = alt_sel | (instr_cnt_q == `INSTR_DIV_LAST);

	// ----------------------------------------
	// Prescaler and edge detection
	// ----------------------------------------
	// Ripple count of source pulses
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			psc_cnt_q <= '0;
		end else if (src_pulse) begin
			psc_cnt_q <= psc_cnt_q + 1'b1;
		end
	end

	// Timer clock taken after the prescaler
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_bit_q <= 1'b0;
			clk_prev_q <= 1'b0;
		end else begin
			clk_bit_q <= psc_cnt_q[prescale];
			clk_prev_q <= clk_bit_q;
		end
	end

	// Rising and falling edges never share a cycle
	assign tick.rise = clk_bit_q & ~clk_prev_q;
	assign tick.fall = ~clk_bit_q & clk_prev_q;

	// Instruction clock pulses are never adjacent
	instr_spacing_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(src_pulse && !alt_sel) ##1 !alt_sel |-> !src_pulse)
		else $error("instruction clock pulses too close");

endmodule

// [core/cmp_sync_latch.sv]
`timescale 1ns/1ps

module cmp_sync_latch (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic fall,
	input wire logic sync_en,
	input wire logic cmp_raw,
	output logic cmp_out
);

	// ----------------------------------------
	// Falling-edge latch
	// ----------------------------------------
	logic latch_q; // Comparator level at last falling edge

	// Capture only on the timer clock falling edge
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_q <= 1'b0;
		end else if (fall) begin
			latch_q <= cmp_raw;
		end
	end

	// Latched when enabled, otherwise passed straight through
	assign cmp_out = sync_en ? latch_q : cmp_raw;

endmodule

// [verification/timer_model.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Gated 16-bit timer seen from the block
// ----------------------------------------
module timer_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire cmp_aux_pkg::tick_t tick,
	input wire logic increment,
	output logic [15:0] count,
	output logic [15:0] rises,
	output logic bad
);
	// Count only granted increments
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 16'h0000;
		end else if (increment) begin
			count <= count + 16'h0001;
		end
	end
	// Rising timer clock edges, for reference
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rises <= 16'h0000;
		end else if (tick.rise) begin
			rises <= rises + 16'h0001;
		end
	end
	// Sticky flag: increment away from a rising edge
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bad <= 1'b0;
		end else if (increment && !tick.rise) begin
			bad <= 1'b1;
		end
	end
endmodule

// [verification/test_comparator_timer_gate_sync.sv]
`timescale 1ns/1ps
`include "cmp_aux_defines.svh"

module test_comparator_timer_gate_sync;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, e, bad;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pstrb, lvl, nib;
	logic ca, cb, pin, ton, gen, alt, ha, hb, ven, vcl, vrs, syn, tg, inc;
	logic [1:0] pre;
	logic [15:0] cnt, ris, c0, r0;
	cmp_aux_pkg::tick_t tck;
	int n_mismatch = 0;
	int checked = 0;
	int p;

	comparator_timer_gate_sync u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_a_output(ca), .cmp_b_output(cb),
		.timer_gate_pin(pin), .timer_on(ton), .timer_gate_enable(gen),
		.timer_prescale(pre), .timer_clk(tck), .timer_increment(inc),
		.synced_cmp_b_output(syn), .timer_gate(tg), .timer_alt_clock_select(alt),
		.cmp_a_hysteresis_enable(ha), .cmp_b_hysteresis_enable(hb),
		.vref_enable(ven), .vref_clamp(vcl), .vref_range_select(vrs),
		.vref_level(lvl));

	timer_model u_timer (.ref_clk(ref_clk), .reset_n(reset_n), .tick(tck),
		.increment(inc), .count(cnt), .rises(ris), .bad(bad));

	// Free-running 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, x);
		end
	endtask

	task automatic test_done;
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One APB transfer; read data and error left in r and e
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			test_done;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Wait for a rise (k=0) or fall (k=1) pulse; n is cycles waited
	task automatic wt(input int k, output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while ((k ? tck.fall : tck.rise) !== 1'b1 && n < 300);
		if (n >= 300) begin
			n_mismatch++;
			test_done;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		ca = 1'b1;
		cb = 1'b0;
		pin = 1'b0;
		ton = 1'b0;
		gen = 1'b0;
		pre = 2'h0;
		reset_n = 1'b0;
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		// Reset values and mirrors
		apb(1'b0, `AUX_CTRL_OFFSET, 32'h0);
		chk(r, 32'h82);
		apb(1'b0, `VREF_CTRL_OFFSET, 32'h0);
		chk(r, 32'h0);
		chk(vcl, 1'b1);
		ca <= 1'b0;
		cb <= 1'b1;
		apb(1'b1, `AUX_CTRL_OFFSET, 32'hFFFF_FFFF);
		apb(1'b0, `AUX_CTRL_OFFSET, 32'h0);
		chk(r, 32'h5F);
		chk({alt, ha, hb}, 3'h7);
		// Masked write ignored, repeated read unchanged
		pstrb <= 4'h0;
		apb(1'b1, `AUX_CTRL_OFFSET, 32'h0);
		pstrb <= 4'hF;
		apb(1'b0, `AUX_CTRL_OFFSET, 32'h0);
		chk(r, 32'h5F);
		// Reference controls
		apb(1'b1, `VREF_CTRL_OFFSET, 32'hFF);
		apb(1'b0, `VREF_CTRL_OFFSET, 32'h0);
		chk(r, 32'hAF);
		chk({ven, vcl, vrs, lvl}, 7'h5F);
		apb(1'b1, `VREF_CTRL_OFFSET, 32'h05);
		apb(1'b0, `VREF_CTRL_OFFSET, 32'h0);
		chk({ven, vcl, vrs, lvl}, 7'h25);
		// Unmapped address refused
		apb(1'b0, 12'h008, 32'h0);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		chk(r, 32'h0000_0000);
		// Gate source: pin, then raw comparator
		apb(1'b1, `AUX_CTRL_OFFSET, 32'h02);
		for (int v = 0; v < 2; v++) begin
			@(posedge ref_clk);
			pin <= v[0];
			@(negedge ref_clk);
			chk(tg, v[0]);
		end
		apb(1'b1, `AUX_CTRL_OFFSET, 32'h0);
		for (int v = 0; v < 2; v++) begin
			@(posedge ref_clk);
			cb <= v[0];
			@(negedge ref_clk);
			chk({tg, syn}, {2{v[0]}});
		end
		// Timer clock period per source and prescale
		for (int a = 0; a < 2; a++) begin
			for (int q = 0; q < 4; q++) begin
				apb(1'b1, `AUX_CTRL_OFFSET, a ? 32'h10 : 32'h00);
				pre <= 2'(q);
				repeat (2) @(posedge ref_clk);
				wt(0, p);
				wt(0, p);
				chk(p, (a ? 2 : 8) << q);
			end
		end
		// Synchronised comparator gate, latched on falls only
		apb(1'b1, `AUX_CTRL_OFFSET, 32'h11);
		pre <= 2'h1;
		for (int v = 0; v < 4; v++) begin
			wt(0, p);
			@(posedge ref_clk);
			cb <= v[0];
			@(negedge ref_clk);
			chk(syn, !v[0]);
			wt(1, p);
			@(negedge ref_clk);
			chk({tg, syn}, {2{v[0]}});
		end
		// Increments: rows of {timer_on, gate_enable, pin, expected}
		pre <= 2'h0;
		apb(1'b1, `AUX_CTRL_OFFSET, 32'h12);
		for (int k = 0; k < 4; k++) begin
			nib = 4'(16'hCF69 >> (12 - 4 * k));
			@(posedge ref_clk);
			{ton, gen, pin} <= nib[3:1];
			@(negedge ref_clk);
			c0 = cnt;
			r0 = ris;
			repeat (40) @(negedge ref_clk);
			chk(ris - r0, 16'h0014);
			chk(cnt - c0, nib[0] ? 16'h0014 : 16'h0000);
		end
		chk(bad, 1'b0);
		test_done;
	end
endmodule
